// [hw/lpc_rd_cfg.svh]
// Bus codes, field positions and counts for the read target
`ifndef LPC_RD_CFG_SVH
`define LPC_RD_CFG_SVH
`define START_CODE 4'h0
`define WAIT_SYNC_CODE 4'h5
`define READY_SYNC_CODE 4'h0
`define TAR_CODE 4'hF
`define CT_MEM_READ 3'h2
`define CT_MEM_WRITE 3'h3
`define ADDR_NIBBLES 3'h7
`define ADDR_SPACE_BIT 23
`define STRAP_HI 22
`define STRAP_LO 20
`define LOC_HI 19
`define MIN_WAIT_SYNCS 4'h2
`define WAIT_SAT 4'hF
`endif

// [hw/lpc_rd_pkg.sv]
// Types shared by the memory read target: bus states, read modes, state record
package lpc_rd_pkg;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_CTYPE = 9'h002,
    ST_ADDR = 9'h004,
    ST_HTAR0 = 9'h008,
    ST_HTAR1 = 9'h010,
    ST_SYNC = 9'h020,
    ST_DLO = 9'h040,
    ST_DHI = 9'h080,
    ST_DTAR = 9'h100
  } bus_state_t;

  typedef enum logic [2:0] {
    MODE_ARRAY = 3'h1,
    MODE_IDENT = 3'h2,
    MODE_STATUS = 3'h4
  } read_mode_t;

  typedef struct packed {
    logic [2:0] clk_sync;
    logic clk_stable;
    logic [2:0] frame_sync;
    logic frame_dly;
    logic [3:0] lad_s1;
    logic [3:0] lad_s2;
    logic [3:0] lad_s3;
    logic [3:0] lad_dly;
    bus_state_t state;
    logic [2:0] nib_cnt;
    logic [31:0] addr;
    logic [2:0] strap;
    logic strap_cap;
    read_mode_t mode;
    logic pending;
    logic data_ok;
    logic [7:0] data;
    logic [3:0] waits;
    logic [3:0] lad_out;
    logic lad_oe;
    logic mem_req;
    logic [19:0] mem_addr;
    logic mem_array;
    logic busy;
  } target_state_t;
endpackage : lpc_rd_pkg

// [hw/lpc_memory_read_target.sv]
// Target end of the low-pin-count memory read cycle for a flash device
// Notes on behaviour
// - Start is nibble 0000b sampled with frame low at a bus clock rise.
// - With frame held low over several clocks only the last start counts.
// - Cycle-type nibble 010x is memory read, 011x memory write, bit 0 reserved.
// - Eight address nibbles follow, most significant first, forming 32 bits.
// - Address bit 23 high selects the array, low selects register space.
// - Bits 22..20 are identity strap bits, bits 19..0 the memory location.
// - Turnaround is two clocks: all ones driven, then lines released.
// - Target takes the bus only after the host's second turnaround clock.
// - Wait sync 0101b while not ready, then ready sync 0000b once.
// - Reference timing gives two wait syncs then ready; count may vary.
// - Data byte follows ready sync, low nibble first then high nibble.
// - After data the target drives 1111b one clock, then floats.
// - Host turnaround begins right after the eight address clocks.
// - Every field is driven and sampled valid at its clock's rising edge.
// - After reset the target is in read-array mode.
// - Array, identity, lock and input register reads all served the same way.
// - Whenever frame is sampled low, stop driving on the next clock.
`timescale 1ns/1ps
`include "lpc_rd_cfg.svh"

module lpc_memory_read_target
  import lpc_rd_pkg::*;
#(
  parameter logic [3:0] MIN_WAIT_SYNCS = `MIN_WAIT_SYNCS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic lclk,
  input wire logic lframe_n,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe,
  input wire logic [2:0] dev_strap,
  output logic mem_req,
  output logic [19:0] mem_addr,
  output logic mem_array,
  input wire logic mem_ack,
  input wire logic [7:0] mem_data,
  input wire logic mode_load,
  input wire logic [2:0] mode_code,
  output logic [2:0] read_mode,
  output logic cycle_active
);

  target_state_t st_ff;
  target_state_t nxt_st;
  logic bus_edge;
  logic frame_low;
  logic [3:0] lad_now;
  logic [3:0] nxt_waits;

  // Bus clock rise, counted only once stages two and three agree
  assign bus_edge = (st_ff.clk_sync[1] == st_ff.clk_sync[2]) && st_ff.clk_sync[2]
                    && !st_ff.clk_stable;
  // Pins sampled one stage later than the clock so setup before the rise is seen
  assign frame_low = !st_ff.frame_dly;
  assign lad_now = st_ff.lad_dly;

  // Saturating count of wait syncs already on the bus
  assign nxt_waits = (st_ff.waits == `WAIT_SAT) ? st_ff.waits : st_ff.waits + 4'h1;

  // Next-state logic for synchronisers, decoder and bus driver
  always_comb begin
    nxt_st = st_ff;
    nxt_st.mem_req = 1'b0;
    // Three-stage synchronisers; stage one feeds only stage two
    nxt_st.clk_sync = {st_ff.clk_sync[1:0], lclk};
    nxt_st.frame_sync = {st_ff.frame_sync[1:0], lframe_n};
    nxt_st.lad_s1 = lad_in;
    nxt_st.lad_s2 = st_ff.lad_s1;
    nxt_st.lad_s3 = st_ff.lad_s2;
    if (st_ff.clk_sync[1] == st_ff.clk_sync[2]) begin
      nxt_st.clk_stable = st_ff.clk_sync[2];
    end
    if (st_ff.frame_sync[1] == st_ff.frame_sync[2]) begin
      nxt_st.frame_dly = st_ff.frame_sync[2];
    end
    if (st_ff.lad_s2 == st_ff.lad_s3) begin
      nxt_st.lad_dly = st_ff.lad_s3;
    end
    // Strap caught once, the cycle after reset is released
    if (st_ff.strap_cap) begin
      nxt_st.strap = dev_strap;
      nxt_st.strap_cap = 1'b0;
    end
    // Command front end may change the read mode between cycles
    if (mode_load) begin
      nxt_st.mode = read_mode_t'(mode_code);
    end
    // Memory answer; array, identity, lock and input reads all land here
    if (mem_ack && st_ff.pending) begin
      nxt_st.data = mem_data;
      nxt_st.data_ok = 1'b1;
      nxt_st.pending = 1'b0;
    end
    if (bus_edge) begin
      if (frame_low) begin
        // Frame low aborts anything and re-arms start detection
        nxt_st.lad_oe = 1'b0;
        nxt_st.pending = 1'b0;
        nxt_st.data_ok = 1'b0;
        // A later start overwrites any earlier one while frame stays low
        nxt_st.state = (lad_now == `START_CODE) ? ST_CTYPE : ST_IDLE;
      end else begin
        unique case (st_ff.state)
          ST_IDLE: begin
            nxt_st.state = ST_IDLE;
          end
          ST_CTYPE: begin
            // Writes and foreign cycle types are ignored here
            if (lad_now[3:1] == `CT_MEM_READ) begin
              nxt_st.state = ST_ADDR;
              nxt_st.nib_cnt = 3'h0;
            end else begin
              nxt_st.state = ST_IDLE;
            end
          end
          ST_ADDR: begin
            nxt_st.addr = {st_ff.addr[27:0], lad_now};
            nxt_st.nib_cnt = st_ff.nib_cnt + 3'h1;
            if (st_ff.nib_cnt == `ADDR_NIBBLES) begin
              nxt_st.state = ST_HTAR0;
            end
          end
          ST_HTAR0: begin
            // Access starts during host turnaround to hide its latency
            if (st_ff.addr[`STRAP_HI:`STRAP_LO] == st_ff.strap) begin
              nxt_st.state = ST_HTAR1;
              nxt_st.mem_req = 1'b1;
              nxt_st.mem_addr = st_ff.addr[`LOC_HI:0];
              nxt_st.mem_array = st_ff.addr[`ADDR_SPACE_BIT];
              nxt_st.pending = 1'b1;
              nxt_st.data_ok = 1'b0;
            end else begin
              nxt_st.state = ST_IDLE;
            end
          end
          ST_HTAR1: begin
            // Host has released the lines; first sync is due next clock
            nxt_st.state = ST_SYNC;
            nxt_st.lad_oe = 1'b1;
            nxt_st.waits = 4'h0;
            nxt_st.lad_out = (st_ff.data_ok && MIN_WAIT_SYNCS == 4'h0) ?
                             `READY_SYNC_CODE : `WAIT_SYNC_CODE;
          end
          ST_SYNC: begin
            if (st_ff.lad_out == `READY_SYNC_CODE) begin
              nxt_st.state = ST_DLO;
              nxt_st.lad_out = st_ff.data[3:0];
            end else begin
              nxt_st.waits = nxt_waits;
              nxt_st.lad_out = (st_ff.data_ok && nxt_waits >= MIN_WAIT_SYNCS) ?
                               `READY_SYNC_CODE : `WAIT_SYNC_CODE;
            end
          end
          ST_DLO: begin
            nxt_st.state = ST_DHI;
            nxt_st.lad_out = st_ff.data[7:4];
          end
          ST_DHI: begin
            nxt_st.state = ST_DTAR;
            nxt_st.lad_out = `TAR_CODE;
          end
          ST_DTAR: begin
            nxt_st.state = ST_IDLE;
            nxt_st.lad_oe = 1'b0;
          end
          default: begin
            nxt_st.state = ST_IDLE;
            nxt_st.lad_oe = 1'b0;
          end
        endcase
      end
    end
    nxt_st.busy = (nxt_st.state != ST_IDLE);
  end

  // Single state register; reset lands in read-array mode off the bus
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_ff <= '0;
      // Clock stages start high and settled, so a pin already high is no false rise
      st_ff.clk_sync <= 3'h7;
      st_ff.clk_stable <= 1'b1;
      st_ff.frame_sync <= 3'h7;
      st_ff.frame_dly <= 1'b1;
      st_ff.state <= ST_IDLE;
      st_ff.mode <= MODE_ARRAY;
      st_ff.strap_cap <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign lad_out = st_ff.lad_out;
  assign lad_oe = st_ff.lad_oe;
  assign mem_req = st_ff.mem_req;
  assign mem_addr = st_ff.mem_addr;
  assign mem_array = st_ff.mem_array;
  assign read_mode = st_ff.mode;
  assign cycle_active = st_ff.busy;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  AST_START_SEEN: assert property (
    bus_edge && frame_low && lad_now == `START_CODE |=> st_ff.state == ST_CTYPE)
    else $error("start nibble not taken");

  AST_LAST_START: assert property (
    bus_edge && frame_low && lad_now != `START_CODE |=> st_ff.state == ST_IDLE)
    else $error("stale start kept while frame low");

  AST_ABORT_RELEASE: assert property (
    bus_edge && frame_low |=> !lad_oe)
    else $error("bus still driven after frame low");

  AST_FOREIGN_CYCLE: assert property (
    bus_edge && !frame_low && st_ff.state == ST_CTYPE && lad_now[3:1] != `CT_MEM_READ
    |=> st_ff.state == ST_IDLE)
    else $error("non-read cycle type accepted");

  AST_ADDR_DONE: assert property (
    bus_edge && !frame_low && st_ff.state == ST_ADDR && st_ff.nib_cnt == `ADDR_NIBBLES
    |=> st_ff.state == ST_HTAR0 && st_ff.addr[3:0] == $past(lad_now))
    else $error("address not complete after eight nibbles");

  AST_REQ_SPACE: assert property (
    mem_req |-> mem_array == st_ff.addr[`ADDR_SPACE_BIT]
                && mem_addr == st_ff.addr[`LOC_HI:0])
    else $error("access steered to wrong space");

  AST_TAKE_BUS: assert property (
    $rose(lad_oe) |-> $past(st_ff.state) == ST_HTAR1 && st_ff.state == ST_SYNC)
    else $error("bus taken outside host turnaround");

  AST_SYNC_CODES: assert property (
    lad_oe && st_ff.state == ST_SYNC
    |-> lad_out == `WAIT_SYNC_CODE || lad_out == `READY_SYNC_CODE)
    else $error("illegal sync code");

  AST_MIN_WAITS: assert property (
    st_ff.state == ST_SYNC && lad_out == `READY_SYNC_CODE && !$stable(lad_out)
    |-> st_ff.waits >= MIN_WAIT_SYNCS)
    else $error("ready sync before minimum waits");

  AST_LOW_NIBBLE: assert property (
    st_ff.state == ST_DLO |-> lad_oe && lad_out == st_ff.data[3:0])
    else $error("low data nibble wrong");

  AST_TAR_RELEASE: assert property (
    st_ff.state == ST_DTAR && bus_edge && !frame_low
    |=> !lad_oe && st_ff.state == ST_IDLE && $past(lad_out) == `TAR_CODE)
    else $error("turnaround back to host wrong");

  AST_ARRAY_MODE: assert property (
    $fell(srst) |-> read_mode == MODE_ARRAY)
    else $error("not in read-array mode after reset");

  // Field-by-field checks of the read cycle
  AST_READ_TYPE: assert property (
    bus_edge && !frame_low && st_ff.state == ST_CTYPE && lad_now[3:1] == `CT_MEM_READ
    |=> st_ff.state == ST_ADDR && st_ff.nib_cnt == 3'h0)
    else $error("memory read cycle type not accepted");

  AST_STRAP_MISS: assert property (
    bus_edge && !frame_low && st_ff.state == ST_HTAR0
    && st_ff.addr[`STRAP_HI:`STRAP_LO] != st_ff.strap
    |=> !mem_req && st_ff.state == ST_IDLE)
    else $error("cycle for another strap not dropped");

  AST_REQ_PULSE: assert property (
    mem_req |=> !mem_req)
    else $error("memory request longer than one cycle");

  AST_DATA_TAKEN: assert property (
    mem_ack && st_ff.pending && !(bus_edge && frame_low)
    |=> st_ff.data_ok && st_ff.data == $past(mem_data))
    else $error("memory answer not captured");

  AST_WAIT_HOLD: assert property (
    bus_edge && !frame_low && st_ff.state == ST_SYNC
    && lad_out == `WAIT_SYNC_CODE && !st_ff.data_ok
    |=> st_ff.state == ST_SYNC && lad_out == `WAIT_SYNC_CODE)
    else $error("ready sync without data");

  AST_READY_ONCE: assert property (
    bus_edge && !frame_low && st_ff.state == ST_SYNC && lad_out == `READY_SYNC_CODE
    |=> st_ff.state == ST_DLO && lad_out == st_ff.data[3:0])
    else $error("ready sync not followed by data");

  AST_HIGH_NIBBLE: assert property (
    bus_edge && !frame_low && st_ff.state == ST_DLO
    |=> st_ff.state == ST_DHI && lad_oe && lad_out == st_ff.data[7:4])
    else $error("high data nibble wrong");

  AST_TAR_DRIVE: assert property (
    bus_edge && !frame_low && st_ff.state == ST_DHI
    |=> st_ff.state == ST_DTAR && lad_oe && lad_out == `TAR_CODE)
    else $error("all-ones turnaround not driven");

  AST_DRIVE_WINDOW: assert property (
    lad_oe |-> st_ff.state == ST_SYNC || st_ff.state == ST_DLO
               || st_ff.state == ST_DHI || st_ff.state == ST_DTAR)
    else $error("nibble bus driven outside the target fields");

  AST_FIELD_HOLD: assert property (
    !bus_edge |=> $stable(lad_out) && $stable(lad_oe))
    else $error("bus output moved between bus clock rises");

endmodule : lpc_memory_read_target

// [verification/lpc_host_model.sv]
// Host bus controller model: bus clock, frame and nibble bus for the read target
`timescale 1ns/1ps
module lpc_host_model (
  input wire logic ref_clk,
  output logic lclk,
  output logic lframe_n,
  output logic [3:0] lad_w,
  input wire logic [3:0] lad_out,
  input wire logic lad_oe
);
  logic [2:0] cnt = 3'h0;
  logic [3:0] hlad = 4'hF;
  logic hoe = 1'b0;
  logic fr_n = 1'b1;
  logic [3:0] seen_lad [16];
  logic seen_oe [16];
  logic any_oe;
  // Free-running bus clock, eight system clocks per period
  always @(posedge ref_clk) cnt <= cnt + 3'h1;
  assign lclk = ~cnt[2];
  assign lframe_n = fr_n;
  // Released lines float up to all ones on the pull-ups
  assign lad_w = lad_oe ? lad_out : (hoe ? hlad : 4'hF);
  // Fields change 24 ns after the bus clock rise, well past the hold need
  task automatic drv(input logic f, input logic [3:0] v, input logic oe);
    @(posedge ref_clk iff cnt == 3'h5);
    fr_n <= f;
    hlad <= v;
    hoe <= oe;
  endtask : drv
  // One cycle: stray frame-low nibble, start, type, address, turnaround, watch
  task automatic run(input logic [3:0] pre, input logic [3:0] ct, input logic [31:0] a,
    input int ab);
    drv(1'b0, pre, 1'b1);
    drv(1'b0, 4'h0, 1'b1);
    drv(1'b1, ct, 1'b1);
    for (int i = 7; i >= 0; i--) drv(1'b1, a[i*4 +: 4], 1'b1);
    drv(1'b1, 4'hF, 1'b1);
    drv(1'b1, 4'hF, 1'b0);
    any_oe = 1'b0;
    // Host stays off the bus until the target has let go
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk iff cnt == 3'h7);
      seen_lad[i] = lad_w;
      seen_oe[i] = lad_oe;
      any_oe |= lad_oe;
      if (ab != 0 && i == ab - 1) drv(1'b0, 4'hF, 1'b0);
      if (ab != 0 && i == ab) drv(1'b1, 4'hF, 1'b0);
    end
  endtask : run
endmodule : lpc_host_model

// [verification/tb_top.sv]
// Self-checking bench: host model, memory responder, read and refusal scenarios
`timescale 1ns/1ps
`include "lpc_rd_cfg.svh"
module tb_top;
  import lpc_rd_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic lclk, lframe_n, lad_oe, mem_req, mem_array, cycle_active;
  logic mem_ack = 1'b0;
  logic mode_load = 1'b0;
  logic [3:0] lad_w, lad_out;
  logic [2:0] dev_strap = 3'h5;
  logic [2:0] mode_code = 3'h1;
  logic [2:0] read_mode;
  logic [19:0] mem_addr;
  logic [7:0] mem_data = 8'h00;
  int fail_count = 0, comparisons = 0, ack_dly = 1, dcnt = 0, nreq = 0;
  logic act_hi = 1'b0;
  // Notes whether the target ever reported a decoded cycle
  always @(posedge ref_clk) begin
    if (cycle_active === 1'b1) act_hi <= 1'b1;
  end
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  lpc_host_model u_host (.ref_clk(ref_clk), .lclk(lclk), .lframe_n(lframe_n),
    .lad_w(lad_w), .lad_out(lad_out), .lad_oe(lad_oe));
  lpc_memory_read_target DUT (.ref_clk(ref_clk), .srst(srst), .lclk(lclk),
    .lframe_n(lframe_n), .lad_in(lad_w), .lad_out(lad_out), .lad_oe(lad_oe),
    .dev_strap(dev_strap), .mem_req(mem_req), .mem_addr(mem_addr), .mem_array(mem_array),
    .mem_ack(mem_ack), .mem_data(mem_data), .mode_load(mode_load), .mode_code(mode_code),
    .read_mode(read_mode), .cycle_active(cycle_active));
  function automatic logic [7:0] dfun(input logic [19:0] a);
    return a[7:0] ^ a[19:12] ^ 8'h5A;
  endfunction : dfun
  // Memory answers each request after ack_dly system clocks
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    if (mem_req === 1'b1) begin
      dcnt <= ack_dly;
      nreq <= nreq + 1;
    end else if (dcnt == 1) begin
      mem_ack <= 1'b1;
      mem_data <= dfun(mem_addr);
      dcnt <= 0;
    end else if (dcnt > 1) begin
      dcnt <= dcnt - 1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rd(input logic [31:0] a, input int dly);
    int w;
    logic [7:0] d;
    logic r;
    r = 1'($urandom);
    ack_dly = dly;
    nreq = 0;
    d = dfun(a[19:0]);
    act_hi = 1'b0;
    u_host.run(4'($urandom), {`CT_MEM_READ, r}, a, 0);
    w = 1;
    while (w < 11 && u_host.seen_lad[w] === `WAIT_SYNC_CODE) w++;
    chk("take", 2'b10, {u_host.seen_oe[1], u_host.seen_oe[0]});
    if (dly == 1) chk("waits", `MIN_WAIT_SYNCS, w - 1);
    else chk("slow", 1, w - 1 > `MIN_WAIT_SYNCS);
    chk("ready", `READY_SYNC_CODE, u_host.seen_lad[w]);
    chk("lo", d[3:0], u_host.seen_lad[w + 1]);
    chk("hi", d[7:4], u_host.seen_lad[w + 2]);
    chk("tar", `TAR_CODE, u_host.seen_lad[w + 3]);
    chk("rel", 2'b10, {u_host.seen_oe[w + 3], u_host.seen_oe[w + 4]});
    chk("loc", a[19:0], mem_addr);
    chk("space", a[23], mem_array);
    chk("reqs", 1, nreq);
    chk("active", 2'b10, {act_hi, cycle_active});
    $display("test read %h done", a);
  endtask : rd
  task automatic no(input string nm, input logic [3:0] ct, input logic [31:0] a);
    nreq = 0;
    u_host.run(4'hF, ct, a, 0);
    chk(nm, 0, {u_host.any_oe, nreq != 0, cycle_active});
    $display("test %s done", nm);
  endtask : no
  task automatic end_sim();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // Watchdog well beyond the roughly 4000 clocks the tests need
  initial begin
    #60000;
    fail_count++;
    end_sim();
  end
  initial begin
    logic [31:0] a;
    void'($urandom(96307));
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk("mode_rst", 3'h1, read_mode);
    for (int k = 0; k < 3; k++) begin
      mode_load <= 1'b1;
      mode_code <= 3'h1 << ((k + 1) % 3);
      @(posedge ref_clk);
      mode_load <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("mode", 3'h1 << ((k + 1) % 3), read_mode);
    end
    $display("test mode done");
    // Abort in mid-sync while memory is still busy
    ack_dly = 200;
    u_host.run(4'h0, {`CT_MEM_READ, 1'b0}, 32'h00D12345, 3);
    chk("abort", 2'b10, {u_host.seen_oe[2], u_host.seen_oe[4]});
    $display("test abort done");
    rd(32'hFFDFFFFF, 1);
    rd(32'h00500000, 1);
    for (int i = 0; i < 8; i++) begin
      a = $urandom;
      a[22:20] = dev_strap;
      a[23] = i[0];
      rd(a, (i < 4) ? 1 : 60);
    end
    // Second reset from identity mode with a new strap; both must be taken afresh
    mode_load <= 1'b1;
    mode_code <= 3'h2;
    @(posedge ref_clk);
    mode_load <= 1'b0;
    dev_strap <= 3'h6;
    srst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk("mode_rst2", 3'h1, read_mode);
    $display("test reset done");
    rd(32'h12E3456F, 1);
    no("old_strap", {`CT_MEM_READ, 1'b0}, 32'h00D00000);
    no("strap", {`CT_MEM_READ, 1'b0}, 32'h00A00000);
    no("write", {`CT_MEM_WRITE, 1'b1}, 32'h00D00000);
    no("other", 4'h0, 32'h00D00000);
    end_sim();
  end
endmodule : tb_top
